/* File: core/oad_map.vh */
`ifndef OAD_MAP_VH
`define OAD_MAP_VH
`define OAD_WORD_W 44
`define OAD_ADDR_W 10
`define OAD_TANK_W 7
`define OAD_MC_W 3
`define OAD_A1_MSB 43
`define OAD_A2_MSB 33
`define OAD_A3_MSB 23
`define OAD_A4_MSB 13
`define OAD_TYPE_MSB 3
`define OAD_MAG_VIS 3'h1
`define OAD_MAG_HALT 3'h6
`define OAD_SCOPE_W 3
`endif

/* File: core/oad_field_split.v */
`timescale 1ns/1ns
// ----------------------------------------
// address field split and increment
// ----------------------------------------
module oad_field_split #(
    parameter AW = 10,
    parameter TW = 7,
    parameter MW = 3
)(
    input wire [AW-1:0] address_field,
    output wire [TW-1:0] tank,
    output wire [MW-1:0] minor,
    output wire [AW-1:0] incremented
);
    assign tank = address_field[AW-1:MW];
    assign minor = address_field[MW-1:0];
    // carry out of the top bit is dropped
    assign incremented = address_field + {{(AW-1){1'b0}}, 1'b1};
endmodule // oad_field_split

/* File: core/oad_order_decoder.v */
`timescale 1ns/1ns
`include "oad_map.vh"
module oad_order_decoder #(
    parameter WW = `OAD_WORD_W,
    parameter AW = `OAD_ADDR_W
)(
    input wire clk,
    input wire rst_n,
    input wire order_valid,
    input wire [WW-1:0] order_word,
    input wire inc_request,
    input wire [1:0] inc_select,
    input wire mem_rd_ack,
    input wire [WW-1:0] mem_rd_data,
    input wire initiate,
    output wire order_ready,
    output reg [AW-1:0] mem_rd_addr,
    output reg mem_rd_req,
    output wire mem_wr_en,
    output reg [2:0] mc_count_q,
    output reg [WW-1:0] out_term_a_q,
    output reg [WW-1:0] out_term_b_q,
    output reg out_term_valid_q,
    output reg [2:0] scope_ff_q,
    output reg [WW-1:0] next_order_q,
    output reg next_order_valid_q,
    output reg halted_q,
    output reg alarm_audible_q,
    output reg alarm_visual_q,
    output reg unused_order_q,
    output reg [3:0] type_value_q,
    output reg [AW-1:0] addr_field_inc_q,
    output reg [6:0] tank_q,
    output reg [2:0] minor_q
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam S_IDLE = 3'h0;
    localparam S_V1 = 3'h1;
    localparam S_V2 = 3'h2;
    localparam S_V4 = 3'h3;
    localparam S_HALT = 3'h4;
    localparam S_H4 = 3'h5;

    reg [2:0] state_q;
    reg [WW-1:0] order_q;
    reg [WW-1:0] short_tank_q;
    wire [AW-1:0] a1;
    wire [AW-1:0] a2;
    wire [AW-1:0] a3;
    wire [AW-1:0] a4;
    wire [2:0] mag;
    wire neg;
    wire [AW-1:0] inc_src;
    wire [AW-1:0] inc_res;
    wire [6:0] tank_w;
    wire [2:0] minor_w;

    wire is_unused;
    wire is_show;
    wire is_halt;
    wire [2:0] scope_d;
    reg [2:0] state_d;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    assign a1 = order_q[`OAD_A1_MSB -: AW];
    assign a2 = order_q[`OAD_A2_MSB -: AW];
    assign a3 = order_q[`OAD_A3_MSB -: AW];
    assign a4 = order_q[`OAD_A4_MSB -: AW];
    assign mag = order_word[`OAD_TYPE_MSB:1];
    assign neg = order_word[0];

    // order-type classes of the offered word
    assign is_unused = (mag == 3'h0);
    assign is_show = neg && (mag == `OAD_MAG_VIS);
    assign is_halt = !neg && (mag == `OAD_MAG_HALT);
    assign order_ready = (state_q == S_IDLE);
    assign mem_wr_en = 1'b0;

    assign inc_src = (inc_select == 2'h0) ? order_word[`OAD_A1_MSB -: AW] :
                     (inc_select == 2'h1) ? order_word[`OAD_A2_MSB -: AW] :
                     (inc_select == 2'h2) ? order_word[`OAD_A3_MSB -: AW] :
                     order_word[`OAD_A4_MSB -: AW];

    oad_field_split #(
        .AW(AW),
        .TW(`OAD_TANK_W),
        .MW(`OAD_MC_W)
    ) u_split (
        .address_field(inc_src),
        .tank(tank_w),
        .minor(minor_w),
        .incremented(inc_res)
    );

    // ----------------------------------------
    // scope select decode
    // ----------------------------------------
    // one flag per scope, picked by the low two bits of the third field
    genvar gs;
    generate
        for (gs = 0; gs < `OAD_SCOPE_W; gs = gs + 1)
        begin : g_scope
            assign scope_d[gs] = ({30'h0, a3[1:0]} == gs + 1);
        end
    endgenerate

    // ----------------------------------------
    // memory read request
    // ----------------------------------------
    always @*
    begin
        mem_rd_req = 1'b0;
        mem_rd_addr = {AW{1'b0}};
        case (state_q)
            S_V1:
            begin
                mem_rd_req = 1'b1;
                mem_rd_addr = a1;
            end
            S_V2:
            begin
                mem_rd_req = 1'b1;
                mem_rd_addr = a2;
            end
            S_V4, S_H4:
            begin
                mem_rd_req = 1'b1;
                mem_rd_addr = a4;
            end
            default:
            begin
                mem_rd_req = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // display and restart steps advance only on a read acknowledge
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
            begin
                if (order_valid && is_show)
                    state_d = S_V1;
                else if (order_valid && is_halt)
                    state_d = S_HALT;
            end
            S_V1:
            begin
                if (mem_rd_ack)
                    state_d = S_V2;
            end
            S_V2:
            begin
                if (mem_rd_ack)
                    state_d = S_V4;
            end
            S_V4, S_H4:
            begin
                if (mem_rd_ack)
                    state_d = S_IDLE;
            end
            S_HALT:
            begin
                // held here until the operator restarts
                if (initiate)
                    state_d = S_H4;
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= S_IDLE;
            order_q <= {WW{1'b0}};
            short_tank_q <= {WW{1'b0}};
            mc_count_q <= 3'h0;
            out_term_a_q <= {WW{1'b0}};
            out_term_b_q <= {WW{1'b0}};
            out_term_valid_q <= 1'b0;
            scope_ff_q <= 3'h0;
            next_order_q <= {WW{1'b0}};
            next_order_valid_q <= 1'b0;
            halted_q <= 1'b0;
            alarm_audible_q <= 1'b0;
            alarm_visual_q <= 1'b0;
            unused_order_q <= 1'b0;
            type_value_q <= 4'h0;
            addr_field_inc_q <= {AW{1'b0}};
            tank_q <= 7'h00;
            minor_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            mc_count_q <= mc_count_q + 3'h1;
            out_term_valid_q <= 1'b0;
            next_order_valid_q <= 1'b0;
            unused_order_q <= 1'b0;
            if (inc_request)
            begin
                addr_field_inc_q <= inc_res;
                tank_q <= tank_w;
                minor_q <= minor_w;
            end
            case (state_q)
                S_IDLE:
                begin
                    if (order_valid)
                    begin
                        order_q <= order_word;
                        type_value_q <= order_word[`OAD_TYPE_MSB:0];
                        if (is_unused)
                            unused_order_q <= 1'b1;
                        if (is_halt)
                        begin
                            halted_q <= 1'b1;
                            alarm_audible_q <= 1'b1;
                            alarm_visual_q <= 1'b1;
                        end
                    end
                end
                S_V1:
                begin
                    if (mem_rd_ack)
                    begin
                        short_tank_q <= mem_rd_data;
                    end
                end
                S_V2:
                begin
                    if (mem_rd_ack)
                    begin
                        out_term_a_q <= mem_rd_data;
                        out_term_b_q <= short_tank_q;
                        out_term_valid_q <= 1'b1;
                        scope_ff_q <= scope_d;
                    end
                end
                S_V4, S_H4:
                begin
                    if (mem_rd_ack)
                    begin
                        next_order_q <= mem_rd_data;
                        next_order_valid_q <= 1'b1;
                    end
                end
                S_HALT:
                begin
                    if (initiate)
                    begin
                        halted_q <= 1'b0;
                        alarm_audible_q <= 1'b0;
                        alarm_visual_q <= 1'b0;
                    end
                end
                default:
                begin
                    // stray state: drop any halt indication
                    halted_q <= 1'b0;
                    alarm_audible_q <= 1'b0;
                    alarm_visual_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // oad_order_decoder

/* File: verif/oad_chk_assertions.sv */
`timescale 1ns/1ns
// ----
// decoder port checks
// ----
module oad_chk (
    input wire clk,
    input wire rst_n,
    input wire order_valid,
    input wire [43:0] order_word,
    input wire inc_request,
    input wire [1:0] inc_select,
    input wire initiate,
    input wire order_ready,
    input wire [9:0] mem_rd_addr,
    input wire mem_rd_req,
    input wire mem_wr_en,
    input wire [2:0] mc_count_q,
    input wire next_order_valid_q,
    input wire halted_q,
    input wire alarm_audible_q,
    input wire alarm_visual_q,
    input wire unused_order_q,
    input wire [9:0] addr_field_inc_q
);
    wire take = order_valid && order_ready;
    wire [9:0] fld = order_word[43 - 10 * inc_select -: 10];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    mc_wrap_a: assert property ($past(rst_n) |-> mc_count_q == $past(mc_count_q) + 3'h1)
        else $error("count step wrong");
    no_write_a: assert property (!mem_wr_en)
        else $error("memory write");
    zero_type_a: assert property (take && order_word[3:1] == 3'h0 |=> unused_order_q)
        else $error("zero type not flagged");
    halt_flags_a: assert property (take && order_word[3:0] == 4'hC |=>
        halted_q && alarm_audible_q && alarm_visual_q)
        else $error("halt flags missing");
    halt_stay_a: assert property (halted_q && !initiate |=> halted_q)
        else $error("halt left early");
    show_read_a: assert property (take && order_word[3:0] == 4'h3 |=>
        mem_rd_req && mem_rd_addr == $past(order_word[43:34]))
        else $error("first read wrong");
    inc_wrap_a: assert property (inc_request |=> addr_field_inc_q == $past(fld) + 10'h001)
        else $error("increment wrong");
    next_idle_a: assert property (next_order_valid_q |-> order_ready)
        else $error("not idle after next");
endmodule // oad_chk

/* File: verif/oad_mem_model.sv */
`timescale 1ns/1ns
// ----
// read-only store, prompt or slow
// ----
module oad_mem_model (
    input wire clk,
    input wire [1:0] lat,
    input wire mem_rd_req,
    input wire [9:0] mem_rd_addr,
    output reg mem_rd_ack = 1'b0,
    output reg [43:0] mem_rd_data = 44'h0
);
    reg [1:0] cnt_q = 2'h0;
    function automatic [43:0] word_at(input [9:0] a);
        word_at = {a, ~a, a ^ 10'h155, a ^ 10'h2AA, a[3:0]};
    endfunction
    // no write path, contents fixed
    always @(posedge clk)
    begin
        mem_rd_ack <= 1'b0;
        mem_rd_data <= ~mem_rd_data;
        cnt_q <= 2'h0;
        if (mem_rd_req && !mem_rd_ack)
        begin
            cnt_q <= cnt_q + 2'h1;
            if (cnt_q == lat)
            begin
                mem_rd_ack <= 1'b1;
                mem_rd_data <= word_at(mem_rd_addr);
            end
        end
    end
endmodule // oad_mem_model

/* File: verif/order_address_decoder_bench.sv */
`timescale 1ns/1ns
module order_address_decoder_bench;
    reg clk = 1'b0, rst_n = 1'b0, order_valid = 1'b0, inc_request = 1'b0, initiate = 1'b0;
    reg [43:0] order_word = 44'h0;
    reg [1:0] inc_select = 2'h0, lat = 2'h0;
    wire ack, rdy, req, wr, otv, nov, hlt, aud, vis, unu;
    wire [43:0] rdd, ota, otb, nxo;
    wire [9:0] rda, inc;
    wire [2:0] mc, scp, mnr;
    wire [3:0] tv;
    wire [6:0] tnk;
    logic [43:0] exp_q[$];
    logic [31:0] seed = 32'hB4F04AA0;
    int bad_count = 0, compares = 0, cyc = 0;
    always #10 clk = ~clk;
    oad_order_decoder oad_order_decoder_inst (.clk(clk), .rst_n(rst_n), .order_valid(order_valid),
        .order_word(order_word), .inc_request(inc_request), .inc_select(inc_select),
        .mem_rd_ack(ack), .mem_rd_data(rdd), .initiate(initiate), .order_ready(rdy),
        .mem_rd_addr(rda), .mem_rd_req(req), .mem_wr_en(wr), .mc_count_q(mc),
        .out_term_a_q(ota), .out_term_b_q(otb), .out_term_valid_q(otv), .scope_ff_q(scp),
        .next_order_q(nxo), .next_order_valid_q(nov), .halted_q(hlt), .alarm_audible_q(aud),
        .alarm_visual_q(vis), .unused_order_q(unu), .type_value_q(tv),
        .addr_field_inc_q(inc), .tank_q(tnk), .minor_q(mnr));
    oad_mem_model oad_mem_model_inst (.clk(clk), .lat(lat), .mem_rd_req(req),
        .mem_rd_addr(rda), .mem_rd_ack(ack), .mem_rd_data(rdd));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [43:0] wd(input [9:0] a);
        return oad_mem_model_inst.word_at(a);
    endfunction
    task automatic check(input string nm, input logic [43:0] seen, input logic [43:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic send(input [43:0] w);
        @(negedge clk);
        while (!rdy)
            @(negedge clk);
        lat = 2'(rnd());
        order_valid = 1'b1;
        order_word = w;
        @(negedge clk);
        order_valid = 1'b0;
    endtask
    task automatic show(input [9:0] a1, input [9:0] a2, input [9:0] a3, input [9:0] a4);
        exp_q.push_back(wd(a2));
        exp_q.push_back(wd(a1));
        exp_q.push_back(a3[1:0] == 2'h0 ? 44'h0 : 44'h1 << (a3[1:0] - 2'h1));
        exp_q.push_back(wd(a4));
        send({a1, a2, a3, a4, 4'h3});
    endtask
    always @(negedge clk)
    begin
        if (rst_n && otv)
        begin
            check("term a", ota, exp_q.pop_front());
            check("term b", otb, exp_q.pop_front());
            check("scope", {41'h0, scp}, exp_q.pop_front());
        end
        if (rst_n && nov)
            check("next", nxo, exp_q.pop_front());
        if (rst_n && unu)
            check("unused type", {40'h0, tv}, exp_q.pop_front());
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            bad_count++;
            results();
        end
    end
    initial
    begin
        logic [9:0] f;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++)
            show(i == 7 ? 10'h3FF : 10'(rnd()), 10'(rnd()), 10'(i), 10'(rnd()));
        exp_q.push_back(44'h0);
        send(44'h0);
        exp_q.push_back(44'h1);
        send(44'h1);
        send(44'h2);
        send(44'hD);
        send({10'h3FF, 10'h155, 10'h2AA, 10'h1F0, 4'hC});
        repeat (4) @(negedge clk);
        check("halt", {41'h0, hlt, aud, vis}, 44'h7);
        exp_q.push_back(wd(10'h1F0));
        initiate = 1'b1;
        @(negedge clk);
        initiate = 1'b0;
        check("resume", {41'h0, hlt, aud, vis}, 44'h0);
        show(10'h000, 10'h3FF, 10'h005, 10'(rnd()));
        for (int i = 0; i < 4; i++)
        begin
            f = i == 3 ? 10'h3FF : 10'(rnd());
            order_word = {rnd(), 12'(rnd())};
            order_word[43 - 10 * i -: 10] = f;
            inc_select = 2'(i);
            inc_request = 1'b1;
            @(negedge clk);
            inc_request = 1'b0;
            check("inc", {34'h0, inc}, {34'h0, f + 10'h001});
            check("tank", {37'h0, tnk}, {37'h0, f[9:3]});
            check("minor", {41'h0, mnr}, {41'h0, f[2:0]});
        end
        repeat (40) @(negedge clk);
        check("left", 44'(exp_q.size()), 44'h0);
        results();
    end
endmodule // order_address_decoder_bench
bind oad_order_decoder oad_chk oad_chk_inst (.clk(clk), .rst_n(rst_n), .order_valid(order_valid),
    .order_word(order_word), .inc_request(inc_request), .inc_select(inc_select),
    .initiate(initiate), .order_ready(order_ready), .mem_rd_addr(mem_rd_addr),
    .mem_rd_req(mem_rd_req), .mem_wr_en(mem_wr_en), .mc_count_q(mc_count_q),
    .next_order_valid_q(next_order_valid_q), .halted_q(halted_q),
    .alarm_audible_q(alarm_audible_q), .alarm_visual_q(alarm_visual_q),
    .unused_order_q(unused_order_q), .addr_field_inc_q(addr_field_inc_q));
